// >>> pkg/sysopt_pkg.sv
// Package: register map, reset values and carriers for the option/ID block
package sysopt_pkg;
    // Register byte addresses (APB, one word each)
    localparam logic [11:0] OPT_ONE_ADDR = 12'h000;
    localparam logic [11:0] OPT_TWO_ADDR = 12'h004;
    localparam logic [11:0] PN_HIGH_ADDR = 12'h008;
    localparam logic [11:0] PN_LOW_ADDR = 12'h00c;
    localparam logic [11:0] RST_STAT_ADDR = 12'h010;
    // Reset values
    localparam logic [7:0] OPT_ONE_RESET = 8'hc2;
    localparam logic [7:0] OPT_TWO_RESET = 8'h00;
    // Field positions, options one
    localparam int COP_TO_HI = 7;
    localparam int COP_TO_LO = 6;
    localparam int STOP_ALLOW_BIT = 5;
    localparam int RSVD_BIT = 4;
    localparam int TWI_SEL_BIT = 2;
    localparam int DBG_EN_BIT = 1;
    localparam int RST_EN_BIT = 0;
    // Field positions, options two
    localparam int WD_CLK_BIT = 7;
    localparam int WD_WIN_BIT = 6;
    localparam int CMP_LINK_BIT = 4;
    localparam int CH1_SEL_BIT = 1;
    localparam int CH0_SEL_BIT = 0;
    // Watchdog service key bytes
    localparam logic [7:0] SVC_KEY_ONE = 8'h55;
    localparam logic [7:0] SVC_KEY_TWO = 8'haa;
    // Slow watchdog clock: 1 kHz from 50 MHz
    localparam int CLK_HZ = 50000000;
    localparam int SLOW_HZ = 1000;
    localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
    // Stored options one
    typedef struct packed {
        logic [1:0] copTimeoutSelect;
        logic stopModeAllow;
        logic reservedBit;
        logic twoWirePinSelect;
        logic debugPinEnable;
        logic resetPinEnable;
    } sysopt_one_s;
    // Stored options two
    typedef struct packed {
        logic watchdogClockSelect;
        logic watchdogWindowMode;
        logic comparatorToCaptureLink;
        logic timerCh1PinSelect;
        logic timerCh0PinSelect;
    } sysopt_two_s;
endpackage : sysopt_pkg

// >>> core/sysopt_regs.sv
// System option and part-number registers with a small watchdog
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module sysopt_regs #(
    parameter logic [11:0] PART_NUMBER = 12'h0a5, // Arbitrary value
    parameter logic DERIV_TIE = 1'b0, // Arbitrary value
    parameter int SLOW_DIVIDE = sysopt_pkg::SLOW_DIV,
    parameter int WD_BITS = 18
) (
    // Clock and resets
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic powerOnRst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core events
    input wire logic stopExec,
    // Routing and control outputs
    output logic illegalOpcodeRst,
    output logic watchdogRst,
    output logic twoWireOnPortB,
    output logic debugModePinEn,
    output logic resetPinEn,
    output logic resetPinPullUp,
    output logic cmpToCaptureCh0,
    output logic timerCh1OnPortC,
    output logic timerCh0OnPortC
);
    import sysopt_pkg::*;

    sysopt_one_s optOne_q;
    logic rstPinEn_q;
    sysopt_two_s optTwo_q;
    logic lockOne_q;
    logic lockTwo_q;
    logic keyArmed_q;
    logic [15:0] slowDiv_q;
    logic [WD_BITS-1:0] wdCount_q;
    logic [WD_BITS-1:0] wdLimit;
    logic wdEnable;
    logic windowOn;
    logic wdTick;
    logic wrOne;
    logic wrTwo;
    logic wrStat;
    logic earlyWindow;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode: zero-wait, unmapped reads zero with error
    function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
        return a == b;
    endfunction : hit

    logic mapped;
    logic busWr;
    assign busWr = psel && penable && pwrite;
    assign wrOne = busWr && hit(paddr, OPT_ONE_ADDR);
    assign wrTwo = busWr && hit(paddr, OPT_TWO_ADDR);
    assign wrStat = busWr && hit(paddr, RST_STAT_ADDR);
    assign mapped = hit(paddr, OPT_ONE_ADDR) || hit(paddr, OPT_TWO_ADDR)
        || hit(paddr, PN_HIGH_ADDR) || hit(paddr, PN_LOW_ADDR)
        || hit(paddr, RST_STAT_ADDR);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h0000_0000;
            case (paddr)
                OPT_ONE_ADDR: prdata[7:0] <= {optOne_q.copTimeoutSelect,
                    optOne_q.stopModeAllow, optOne_q.reservedBit, 1'b0,
                    optOne_q.twoWirePinSelect, optOne_q.debugPinEnable,
                    rstPinEn_q};
                OPT_TWO_ADDR: prdata[7:0] <= {optTwo_q.watchdogClockSelect,
                    optTwo_q.watchdogWindowMode, 1'b0,
                    optTwo_q.comparatorToCaptureLink, 2'b00,
                    optTwo_q.timerCh1PinSelect, optTwo_q.timerCh0PinSelect};
                // Reserved 6:4 read zero
                PN_HIGH_ADDR: prdata[7:0] <= {DERIV_TIE, 3'b000,
                    PART_NUMBER[11:8]};
                PN_LOW_ADDR: prdata[7:0] <= PART_NUMBER[7:0];
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Options one, write-once
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            lockOne_q <= 1'b0;
        end else if (wrOne) begin
            lockOne_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            optOne_q <= sysopt_one_s'({OPT_ONE_RESET[7:4],
                OPT_ONE_RESET[2:0]});
        end else if (wrOne && !lockOne_q) begin
            optOne_q <= sysopt_one_s'({pwdata[7:4], pwdata[2:0]});
        end
    end

    // Separate reset domain: only power-on clears it
    always_ff @(posedge ref_clk or negedge powerOnRst_b) begin
        if (!powerOnRst_b) begin
            rstPinEn_q <= 1'b0;
        end else if (wrOne && !lockOne_q && !rstPinEn_q) begin
            rstPinEn_q <= pwdata[RST_EN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Options two: locked bits plus free routing bits
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            lockTwo_q <= 1'b0;
        end else if (wrTwo) begin
            lockTwo_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            optTwo_q <= sysopt_two_s'({OPT_TWO_RESET[7:6],
                OPT_TWO_RESET[4], OPT_TWO_RESET[1:0]});
        end else if (wrTwo) begin
            if (!lockTwo_q) begin
                optTwo_q.watchdogClockSelect <= pwdata[WD_CLK_BIT];
                optTwo_q.watchdogWindowMode <= pwdata[WD_WIN_BIT];
            end
            optTwo_q.comparatorToCaptureLink <= pwdata[CMP_LINK_BIT];
            optTwo_q.timerCh1PinSelect <= pwdata[CH1_SEL_BIT];
            optTwo_q.timerCh0PinSelect <= pwdata[CH0_SEL_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Routing outputs
    assign twoWireOnPortB = optOne_q.twoWirePinSelect;
    assign debugModePinEn = optOne_q.debugPinEnable;
    assign resetPinEn = rstPinEn_q;
    assign resetPinPullUp = rstPinEn_q;
    assign cmpToCaptureCh0 = optTwo_q.comparatorToCaptureLink;
    assign timerCh1OnPortC = optTwo_q.timerCh1PinSelect;
    assign timerCh0OnPortC = optTwo_q.timerCh0PinSelect;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            illegalOpcodeRst <= 1'b0;
        end else begin
            illegalOpcodeRst <= stopExec && !optOne_q.stopModeAllow;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog: period scale is a simplification, 2^(8+2*sel) ticks
    assign wdEnable = optOne_q.copTimeoutSelect != 2'b00;
    assign windowOn = optTwo_q.watchdogWindowMode
        && optTwo_q.watchdogClockSelect;
    assign wdLimit = WD_BITS'(1) << (8 + 2 * optOne_q.copTimeoutSelect);
    assign earlyWindow = windowOn
        && (wdCount_q < wdLimit - (wdLimit >> 2));

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            slowDiv_q <= 16'h0000;
        end else if (slowDiv_q == 16'(SLOW_DIVIDE - 1)) begin
            slowDiv_q <= 16'h0000;
        end else begin
            slowDiv_q <= slowDiv_q + 16'h0001;
        end
    end
    // Bus clock or 1 kHz tick
    assign wdTick = optTwo_q.watchdogClockSelect
        || (slowDiv_q == 16'(SLOW_DIVIDE - 1));

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            keyArmed_q <= 1'b0;
        end else if (wrStat) begin
            keyArmed_q <= pwdata[7:0] == SVC_KEY_ONE;
        end
    end

    logic svcDone;
    logic badWrite;
    assign svcDone = wrStat && keyArmed_q
        && pwdata[7:0] == SVC_KEY_TWO;
    assign badWrite = wrStat && (earlyWindow
        || (pwdata[7:0] != SVC_KEY_ONE && pwdata[7:0] != SVC_KEY_TWO));

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wdCount_q <= '0;
        end else if (!wdEnable || svcDone) begin
            wdCount_q <= '0;
        end else if (wdTick && wdCount_q < wdLimit) begin
            wdCount_q <= wdCount_q + WD_BITS'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            watchdogRst <= 1'b0;
        end else begin
            watchdogRst <= wdEnable && (wdCount_q >= wdLimit
                || badWrite);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    a_lock_one_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
        lockOne_q && wrOne |=> $stable(optOne_q))
        else $error("options one changed after lock");
    a_lock_two_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
        lockTwo_q && wrTwo |=> $stable(optTwo_q.watchdogClockSelect)
        && $stable(optTwo_q.watchdogWindowMode))
        else $error("options two locked bits changed");
    a_route_free: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wrTwo |=> optTwo_q.timerCh0PinSelect == $past(pwdata[0]))
        else $error("routing bit not written");
    a_stop_illegal: assert property (@(posedge ref_clk) disable iff (!rst_b)
        stopExec && !optOne_q.stopModeAllow |=> illegalOpcodeRst)
        else $error("stop did not force illegal opcode reset");
    a_rstpin_sticky: assert property (@(posedge ref_clk)
        disable iff (!powerOnRst_b)
        rstPinEn_q |=> rstPinEn_q)
        else $error("reset pin enable dropped");
    a_wd_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !wdEnable |=> !watchdogRst)
        else $error("watchdog reset while disabled");
    a_svc_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
        svcDone |=> wdCount_q == '0)
        else $error("service did not clear counter");
    a_window_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !optTwo_q.watchdogClockSelect |-> !earlyWindow)
        else $error("window active on slow clock");
    a_lock_set: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wrOne |=> lockOne_q ##1 lockOne_q)
        else $error("lock flag not set");

    ////////////////////////////////////////////////////////////////////////
    // First writes land field by field, later ones only on free bits
    a_opt_one_first: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        !lockOne_q && wrOne
        |=> optOne_q.stopModeAllow == $past(pwdata[STOP_ALLOW_BIT]))
        else $error("options one first write lost");
    a_timeout_first: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        !lockOne_q && wrOne
        |=> optOne_q.copTimeoutSelect == $past(pwdata[7:6]))
        else $error("timeout select first write lost");
    a_rsvd_store: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        !lockOne_q && wrOne
        |=> optOne_q.reservedBit == $past(pwdata[RSVD_BIT]))
        else $error("reserved bit not stored");
    a_twi_route: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        !lockOne_q && wrOne
        |=> twoWireOnPortB == $past(pwdata[TWI_SEL_BIT]))
        else $error("two-wire pin select not applied");
    a_dbg_route: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        !lockOne_q && wrOne
        |=> debugModePinEn == $past(pwdata[DBG_EN_BIT]))
        else $error("debug pin enable not applied");
    a_pullup_follow: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        resetPinEn
        |-> resetPinPullUp)
        else $error("reset pin without pull-up");
    a_rstpin_first: assert property (
        @(posedge ref_clk) disable iff (!rst_b || !powerOnRst_b)
        !lockOne_q && wrOne && !rstPinEn_q
        |=> resetPinEn == $past(pwdata[RST_EN_BIT]))
        else $error("reset pin enable first write lost");
    a_stop_allowed: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        stopExec && optOne_q.stopModeAllow
        |=> !illegalOpcodeRst)
        else $error("allowed stop forced a reset");
    a_wd_clk_first: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        !lockTwo_q && wrTwo
        |=> optTwo_q.watchdogClockSelect == $past(pwdata[WD_CLK_BIT]))
        else $error("watchdog clock select first write lost");
    a_win_first: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        !lockTwo_q && wrTwo
        |=> optTwo_q.watchdogWindowMode == $past(pwdata[WD_WIN_BIT]))
        else $error("window mode first write lost");
    a_cmp_link: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        wrTwo
        |=> cmpToCaptureCh0 == $past(pwdata[CMP_LINK_BIT]))
        else $error("comparator link not written");
    a_ch1_route: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        wrTwo
        |=> timerCh1OnPortC == $past(pwdata[CH1_SEL_BIT]))
        else $error("channel 1 select not written");
    a_lock_two_set: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        wrTwo
        |=> lockTwo_q)
        else $error("options two lock not set");

    ////////////////////////////////////////////////////////////////////////
    // Watchdog reset causes
    a_early_write: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        wrStat && earlyWindow && wdEnable
        |=> watchdogRst)
        else $error("early service write did not reset");
    a_bad_key: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        wrStat && wdEnable && pwdata[7:0] != SVC_KEY_ONE
        && pwdata[7:0] != SVC_KEY_TWO |=> watchdogRst)
        else $error("bad service byte did not reset");
    a_timeout_fire: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        wdEnable && wdCount_q >= wdLimit
        |=> watchdogRst)
        else $error("timeout did not reset");

    ////////////////////////////////////////////////////////////////////////
    // Read path: fixed part number, data held between reads
    a_ro_high: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        psel && !penable && !pwrite && paddr == PN_HIGH_ADDR
        |=> prdata[3:0] == PART_NUMBER[11:8] && prdata[7] == DERIV_TIE)
        else $error("part number high read wrong");
    a_ro_low: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        psel && !penable && !pwrite && paddr == PN_LOW_ADDR
        |=> prdata[7:0] == PART_NUMBER[7:0])
        else $error("part number low read wrong");
    a_rsvd_zero: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        psel && !penable && !pwrite && paddr == PN_HIGH_ADDR
        |=> prdata[6:4] == 3'b000)
        else $error("reserved part bits not zero");
    a_prdata_hold: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        !(psel && !penable && !pwrite)
        |=> $stable(prdata))
        else $error("read data changed outside a read");
endmodule : sysopt_regs
`default_nettype wire

// >>> testbench/sysopt_regs_tb_top.sv
// Self-checking bench for the system option and part-number registers
`timescale 1ns/100ps
`default_nettype none
module sysopt_regs_tb_top;
    import sysopt_pkg::*;
    localparam logic [11:0] PN = 12'h3c7; // Arbitrary value
    localparam logic DT = 1'b1; // Arbitrary value
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic powerOnRst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic stopExec = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, illegalOpcodeRst, watchdogRst;
    logic twoWireOnPortB, debugModePinEn, resetPinEn, resetPinPullUp;
    logic cmpToCaptureCh0, timerCh1OnPortC, timerCh0OnPortC;
    logic [7:0] rd;
    logic err;
    int mismatches = 0;
    int checks = 0;

    // Short slow-clock divide keeps watchdog runs brief
    sysopt_regs #(.PART_NUMBER(PN), .DERIV_TIE(DT), .SLOW_DIVIDE(4)) i_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .powerOnRst_b(powerOnRst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .stopExec(stopExec),
        .illegalOpcodeRst(illegalOpcodeRst), .watchdogRst(watchdogRst),
        .twoWireOnPortB(twoWireOnPortB), .debugModePinEn(debugModePinEn),
        .resetPinEn(resetPinEn), .resetPinPullUp(resetPinPullUp),
        .cmpToCaptureCh0(cmpToCaptureCh0),
        .timerCh1OnPortC(timerCh1OnPortC), .timerCh0OnPortC(timerCh0OnPortC)
    );

    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task complete_run();
        if (mismatches == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run

    task cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t byte %h expected %h", $time, got, exp);
        end
    endtask : cmp8

    task cmp1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask : cmp1

    // One APB transfer; pready sampled with psel and penable high
    task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            mismatches++;
            complete_run();
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task do_reset(input logic por);
        @(posedge ref_clk);
        rst_b <= 1'b0;
        powerOnRst_b <= ~por;
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        powerOnRst_b <= 1'b1;
    endtask : do_reset

    task stop_try(input logic exp);
        @(posedge ref_clk);
        stopExec <= 1'b1;
        @(posedge ref_clk);
        stopExec <= 1'b0;
        #1 cmp1(illegalOpcodeRst, exp);
    endtask : stop_try

    task service();
        apb(1'b1, RST_STAT_ADDR, SVC_KEY_ONE);
        apb(1'b1, RST_STAT_ADDR, SVC_KEY_TWO);
    endtask : service

    // Quiet for q cycles, then a reset within h cycles if h is above q
    task expect_wd(input int q, input int h);
        logic seen;
        seen = 1'b0;
        repeat (q) begin
            @(posedge ref_clk);
            if (watchdogRst === 1'b1) seen = 1'b1;
        end
        cmp1(seen, 1'b0);
        if (h > q) begin
            repeat (h - q) begin
                @(posedge ref_clk);
                if (watchdogRst === 1'b1) seen = 1'b1;
            end
            cmp1(seen, 1'b1);
        end
    endtask : expect_wd

    task wd_setup(input logic [7:0] o1, input logic [7:0] o2);
        do_reset(1'b0);
        apb(1'b1, OPT_ONE_ADDR, o1);
        apb(1'b1, OPT_TWO_ADDR, o2);
    endtask : wd_setup

    ////////////////////////////////////////////////////////////////////////
    task t_opt_one();
        apb(1'b0, OPT_ONE_ADDR, 8'h00);
        cmp8(rd, 8'hc2);
        cmp1(debugModePinEn, 1'b1);
        stop_try(1'b1);
        apb(1'b1, OPT_ONE_ADDR, 8'h35);
        apb(1'b0, OPT_ONE_ADDR, 8'h00);
        cmp8(rd, 8'h35);
        cmp1(twoWireOnPortB, 1'b1);
        cmp1(debugModePinEn, 1'b0);
        cmp1(resetPinEn & resetPinPullUp, 1'b1);
        stop_try(1'b0);
        apb(1'b1, OPT_ONE_ADDR, 8'hc2);
        apb(1'b0, OPT_ONE_ADDR, 8'h00);
        cmp8(rd, 8'h35);
    endtask : t_opt_one

    task t_opt_two();
        apb(1'b1, OPT_TWO_ADDR, 8'hd3);
        apb(1'b0, OPT_TWO_ADDR, 8'h00);
        cmp8(rd, 8'hd3);
        cmp1(cmpToCaptureCh0 & timerCh1OnPortC & timerCh0OnPortC, 1'b1);
        apb(1'b1, OPT_TWO_ADDR, 8'h00);
        apb(1'b0, OPT_TWO_ADDR, 8'h00);
        cmp8(rd, 8'hc0);
        cmp1(cmpToCaptureCh0 | timerCh1OnPortC | timerCh0OnPortC, 1'b0);
    endtask : t_opt_two

    task t_part_number();
        apb(1'b1, PN_HIGH_ADDR, 8'hff);
        apb(1'b1, PN_LOW_ADDR, 8'hff);
        apb(1'b0, PN_HIGH_ADDR, 8'h00);
        cmp8(rd & 8'h8f, {DT, 3'b000, PN[11:8]});
        cmp1(err, 1'b0);
        apb(1'b0, PN_LOW_ADDR, 8'h00);
        cmp8(rd, PN[7:0]);
        apb(1'b0, 12'h020, 8'h00);
        cmp1(err, 1'b1);
        cmp8(rd, 8'h00);
    endtask : t_part_number

    task t_resets();
        do_reset(1'b0);
        apb(1'b0, OPT_ONE_ADDR, 8'h00);
        cmp8(rd, 8'hc3);
        apb(1'b1, OPT_ONE_ADDR, 8'h00);
        apb(1'b0, OPT_ONE_ADDR, 8'h00);
        cmp8(rd, 8'h01);
        do_reset(1'b1);
        apb(1'b0, OPT_ONE_ADDR, 8'h00);
        cmp8(rd, 8'hc2);
        cmp1(resetPinEn, 1'b0);
    endtask : t_resets

    // Bus-clock watchdog with timeout select 1 runs 1024 cycles
    task t_watchdog();
        wd_setup(8'h40, 8'h80);
        service();
        expect_wd(1000, 1100);
        wd_setup(8'h00, 8'h80);
        service();
        expect_wd(1100, 0);
        wd_setup(8'h40, 8'h80);
        apb(1'b1, RST_STAT_ADDR, 8'h12);
        expect_wd(0, 4);
        wd_setup(8'h40, 8'hc0);
        apb(1'b1, RST_STAT_ADDR, SVC_KEY_ONE);
        expect_wd(0, 4);
        wd_setup(8'h40, 8'h40);
        service();
        expect_wd(20, 0);
    endtask : t_watchdog

    initial begin
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        powerOnRst_b <= 1'b1;
        t_opt_one();
        t_opt_two();
        t_part_number();
        t_resets();
        t_watchdog();
        complete_run();
    end
endmodule : sysopt_regs_tb_top
`default_nettype wire
